// >>> src/tps_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - halt command disarms, goes idle, all layers inactive until re-armed
// - front-panel trigger while idle re-arms the sequencer
// - external input triggers on falling edge; driver must send falling-edge pulse
// - external edges advance a layer only when its source is external
// - after settling plus user delay emit a completion pulse per measurement except with hold source
// - scan bypass with external source pulses on each scan return path
// - arm bypass with external source pulses on each arm return path
// - six independent bus lines, each selectable as input or output
// - bus input triggers drive measurements only with measure source bus
// - asynchronous mode uses separate lines, semi-synchronous one shared line
// - asynchronous bus pulses have the same form as jack pulses
// - async measure needs bus source, async mode, one input and output line
// - configuration rejecting same line for input and output in async mode
// - each bus input starts a measurement; completion pulse on chosen output line
// - scan and arm may use bus with own lines, duplicates allowed
// - bypass skips waiting for a layer's event on first pass only
// - immediate source passes through a layer without waiting
// - hold source stays in a layer until another source chosen
module tps_top import tps_pkg::*; (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external jacks
  input  wire logic        ext_trig_n,
  output logic             meter_done_n,
  // trigger bus
  input  wire logic [5:0]  bus_in,
  output logic      [5:0]  bus_out,
  output logic      [5:0]  bus_oe,
  // measurement engine
  output logic             meas_start,
  output logic             armed
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tps_state_t       st;
    tps_lcfg_t        arm;
    tps_lcfg_t        scan;
    tps_lcfg_t        meas;
    logic [15:0]      delay;
    logic [15:0]      tper;
    logic [29:0]      counts;
    logic             err;
    logic             first;
    logic [CNT_W-1:0] arm_cnt;
    logic [CNT_W-1:0] scan_cnt;
    logic [CNT_W-1:0] meas_cnt;
    logic [16:0]      wcnt;
    logic [15:0]      tcnt;
    logic [7:0]       pcnt;
    logic             jack_n;
    logic [5:0]       oe;
    logic             mstart;
    logic [31:0]      rdata;
    logic             rdy;
    logic             serr;
    // registered copies of pin values, so no decode glitch reaches a pin
    logic             live;
    logic [5:0]       bout;
  } tps_st_t;

  tps_st_t    q_r;
  tps_st_t    q_nxt;
  logic [6:0] fall;

  tps_fall #(.W(7)) u_fall (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_n   ({bus_in, ext_trig_n}),
    .fall    (fall)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic layer_ev(input tps_lcfg_t c, input logic ext, input logic [5:0] bus,
                                    input logic key, input logic tick);
    logic r;
    r = 1'b0;
    unique case (c.src)
      SRC_IMM:   r = 1'b1;
      SRC_EXT:   r = ext | key;
      SRC_MAN:   r = key;
      SRC_BUS:   r = bus[c.inl] | key;
      SRC_TIMER: r = tick | key;
      SRC_HOLD:  r = 1'b0;
      default:   r = 1'b0;
    endcase
    return r;
  endfunction

  // one-hot mask of a layer's output line, zero unless bus source: semi-synchronous shares the input line
  function automatic logic [5:0] out_mask(input tps_lcfg_t c);
    logic [5:0] m;
    m = '0;
    if (c.src == SRC_BUS) begin
      m = (c.mode == MODE_ASYNC) ? 6'(6'h01 << c.outl) : 6'(6'h01 << c.inl);
    end
    return m;
  endfunction

  function automatic logic cfg_ok(input tps_lcfg_t c);
    return (c.inl <= LINE_MAX) && (c.outl <= LINE_MAX)
           && !(c.mode == MODE_ASYNC && c.inl == c.outl);
  endfunction

  function automatic logic cnt_done(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    return (lim != '0) && ((cnt + 1'b1) == lim);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic             acc;
  logic             wr;
  logic             key;
  logic             halt;
  logic             tick;
  logic             ev;
  logic             fire_jack;
  logic [5:0]       fire_bus;
  logic [CNT_W-1:0] lim_arm;
  logic [CNT_W-1:0] lim_scan;
  logic [CNT_W-1:0] lim_meas;
  tps_lcfg_t        wcfg;

  always_comb begin
    q_nxt     = q_r;
    acc       = psel & penable;
    wr        = acc & q_r.rdy & pwrite;
    key       = wr && paddr == OFS_CTRL && pwdata[CTRL_KEY_BIT];
    halt      = wr && paddr == OFS_CTRL && pwdata[CTRL_HALT_BIT];
    wcfg      = tps_lcfg_t'(pwdata[CFG_W-1:0]);
    lim_meas  = q_r.counts[CNT_W-1:0];
    lim_scan  = q_r.counts[CNT_SCAN_LSB +: CNT_W];
    lim_arm   = q_r.counts[CNT_ARM_LSB +: CNT_W];
    tick      = (q_r.tper != '0) && (q_r.tcnt == q_r.tper);
    ev        = 1'b0;
    fire_jack = 1'b0;
    fire_bus  = '0;
    q_nxt.mstart = 1'b0;
    // error stands only beside pready; held high it would flag the next good access
    q_nxt.serr   = 1'b0;

    // apb: one wait state, read data prepared before pready rises
    q_nxt.rdy  = acc & ~q_r.rdy;
    if (acc && !q_r.rdy) begin
      q_nxt.serr  = 1'b0;
      q_nxt.rdata = '0;
      unique case (paddr)
        OFS_CTRL:   q_nxt.rdata = '0;
        OFS_ARM:    q_nxt.rdata = 32'(q_r.arm);
        OFS_SCAN:   q_nxt.rdata = 32'(q_r.scan);
        OFS_MEAS:   q_nxt.rdata = 32'(q_r.meas);
        OFS_DELAY:  q_nxt.rdata = 32'(q_r.delay);
        OFS_TIMER:  q_nxt.rdata = 32'(q_r.tper);
        OFS_COUNT:  q_nxt.rdata = 32'(q_r.counts);
        // status: state, sticky error, measure count at zero
        OFS_STATUS: q_nxt.rdata = {16'h0000, 11'h000, q_r.meas_cnt == '0, q_r.err, q_r.st};
        default:    q_nxt.serr  = 1'b1;
      endcase
    end

    // timer runs only while armed
    if (q_r.st == ST_IDLE || tick) begin
      q_nxt.tcnt = '0;
    end else begin
      q_nxt.tcnt = q_r.tcnt + 16'h0001;
    end

    // ****************************************
    // trigger layers
    // ****************************************
    unique case (q_r.st)
      ST_IDLE: begin
        if (key) begin
          q_nxt.st       = ST_ARM;
          q_nxt.first    = 1'b1;
          q_nxt.arm_cnt  = '0;
          q_nxt.scan_cnt = '0;
          q_nxt.meas_cnt = '0;
        end
      end
      ST_ARM: begin
        ev = layer_ev(q_r.arm, fall[0], fall[6:1], key, tick);
        if ((q_r.first && q_r.arm.byp) || ev) begin
          q_nxt.st    = ST_SCAN;
          q_nxt.first = 1'b1;
        end
      end
      ST_SCAN: begin
        ev = layer_ev(q_r.scan, fall[0], fall[6:1], key, tick);
        if ((q_r.first && q_r.scan.byp) || ev) begin
          q_nxt.st    = ST_MEAS;
          q_nxt.first = 1'b1;
        end
      end
      ST_MEAS: begin
        ev = layer_ev(q_r.meas, fall[0], fall[6:1], key, tick);
        if ((q_r.first && q_r.meas.byp) || ev) begin
          q_nxt.st     = ST_SETTLE;
          q_nxt.first  = 1'b0;
          q_nxt.mstart = 1'b1;
          q_nxt.wcnt   = 17'(SETTLE_CYC) + 17'(q_r.delay);
        end
      end
      ST_SETTLE: begin
        if (q_r.wcnt != '0) begin
          q_nxt.wcnt = q_r.wcnt - 17'h00001;
        end else begin
          // settle and delay elapsed: completion pulse
          if (q_r.meas.src == SRC_BUS) begin
            fire_bus = out_mask(q_r.meas);
          end else if (q_r.meas.src != SRC_HOLD) begin
            fire_jack = 1'b1;
          end
          q_nxt.meas_cnt = q_r.meas_cnt + 1'b1;
          q_nxt.st       = ST_MEAS;
          if (cnt_done(q_r.meas_cnt, lim_meas)) begin
            // return path through the scan layer
            q_nxt.meas_cnt = '0;
            q_nxt.scan_cnt = q_r.scan_cnt + 1'b1;
            q_nxt.st       = ST_SCAN;
            if (q_r.scan.byp) begin
              fire_jack = fire_jack | (q_r.scan.src == SRC_EXT);
              fire_bus  = fire_bus | out_mask(q_r.scan);
            end
            if (cnt_done(q_r.scan_cnt, lim_scan)) begin
              // return path through the arm layer
              q_nxt.scan_cnt = '0;
              q_nxt.arm_cnt  = q_r.arm_cnt + 1'b1;
              q_nxt.st       = ST_ARM;
              if (q_r.arm.byp) begin
                fire_jack = fire_jack | (q_r.arm.src == SRC_EXT);
                fire_bus  = fire_bus | out_mask(q_r.arm);
              end
              if (cnt_done(q_r.arm_cnt, lim_arm)) begin
                q_nxt.st = ST_IDLE;
              end
            end
          end
        end
      end
      default: q_nxt.st = ST_IDLE;
    endcase

    if (halt) begin
      q_nxt.st     = ST_IDLE;
      q_nxt.first  = 1'b0;
      q_nxt.mstart = 1'b0;
    end

    // ****************************************
    // output pulses
    // ****************************************
    // shared width counter; a new pulse restarts it, so close pulses merge
    if (q_r.pcnt != '0) begin
      q_nxt.pcnt = q_r.pcnt - 8'h01;
    end else begin
      q_nxt.jack_n = 1'b1;
      q_nxt.oe     = '0;
    end
    if (fire_jack || fire_bus != '0) begin
      q_nxt.pcnt   = PULSE_CYC - 8'h01;
      q_nxt.jack_n = q_nxt.jack_n & ~fire_jack;
      q_nxt.oe     = q_nxt.oe | fire_bus;
    end

    // ****************************************
    // register writes
    // ****************************************
    if (wr) begin
      unique case (paddr)
        OFS_ARM: begin
          if (cfg_ok(wcfg)) q_nxt.arm = wcfg; else q_nxt.err = 1'b1;
        end
        OFS_SCAN: begin
          if (cfg_ok(wcfg)) q_nxt.scan = wcfg; else q_nxt.err = 1'b1;
        end
        OFS_MEAS: begin
          if (cfg_ok(wcfg)) q_nxt.meas = wcfg; else q_nxt.err = 1'b1;
        end
        OFS_DELAY:  q_nxt.delay  = pwdata[15:0];
        OFS_TIMER:  q_nxt.tper   = pwdata[15:0];
        OFS_COUNT:  q_nxt.counts = pwdata[29:0];
        OFS_STATUS: begin
          // writing one to the error bit clears the sticky flag
          if (pwdata[STAT_ERR_BIT]) q_nxt.err = 1'b0;
        end
        default: q_nxt.err = q_nxt.err;
      endcase
    end

    // ****************************************
    // pin copies
    // ****************************************
    q_nxt.live = (q_nxt.st != ST_IDLE);
    q_nxt.bout = ~q_nxt.oe;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r        <= '0;
      q_r.st     <= ST_IDLE;
      q_r.delay  <= DELAY_RST;
      q_r.tper   <= TIMER_RST;
      q_r.counts <= COUNT_RST;
      q_r.jack_n <= 1'b1;
      q_r.bout   <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata       = q_r.rdata;
  assign pready       = q_r.rdy;
  assign pslverr      = q_r.serr;
  assign meter_done_n = q_r.jack_n;
  assign bus_oe       = q_r.oe;
  assign bus_out      = q_r.bout;
  assign meas_start   = q_r.mstart;
  assign armed        = q_r.live;

endmodule // tps_top

// >>> src/tps_pkg.sv
package tps_pkg;

  // ****************************************
  // register map (byte addresses, one word each)
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ARM    = 8'h04;
  localparam logic [7:0] OFS_SCAN   = 8'h08;
  localparam logic [7:0] OFS_MEAS   = 8'h0C;
  localparam logic [7:0] OFS_DELAY  = 8'h10;
  localparam logic [7:0] OFS_TIMER  = 8'h14;
  localparam logic [7:0] OFS_COUNT  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_KEY_BIT  = 1;
  localparam int CFG_W         = 11;
  localparam int CNT_W         = 10;
  localparam int CNT_SCAN_LSB  = 10;
  localparam int CNT_ARM_LSB   = 20;
  localparam int STAT_ERR_BIT  = 3;
  localparam int NLINES        = 6;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [2:0] SRC_IMM   = 3'h0;
  localparam logic [2:0] SRC_EXT   = 3'h1;
  localparam logic [2:0] SRC_MAN   = 3'h2;
  localparam logic [2:0] SRC_BUS   = 3'h3;
  localparam logic [2:0] SRC_TIMER = 3'h4;
  localparam logic [2:0] SRC_HOLD  = 3'h5;
  localparam logic       MODE_ASYNC = 1'b0;
  localparam logic [2:0] LINE_MAX   = 3'h5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [29:0] COUNT_RST = 30'h00100000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS     = 50;
  localparam int SETTLE_NS  = 1000;
  localparam int PULSE_NS   = 10000;
  localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PULSE_CYC  = 8'((PULSE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ARM    = 3'h1,
    ST_SCAN   = 3'h2,
    ST_MEAS   = 3'h3,
    ST_SETTLE = 3'h4
  } tps_state_t;

  typedef struct packed {
    logic [2:0] src;
    logic       byp;
    logic       mode;
    logic [2:0] inl;
    logic [2:0] outl;
  } tps_lcfg_t;

endpackage

// >>> src/tps_fall.sv
`timescale 1ns/1ns
module tps_fall import tps_pkg::*; #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and events
  input  wire logic [W-1:0] pin_n,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tps_fall_st_t;

  tps_fall_st_t q_r;
  tps_fall_st_t q_nxt;

  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = pin_n;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // one cycle per high-to-low transition, idle lines rest high
  assign fall = q_r.s3 & ~q_r.s2;

endmodule // tps_fall

// >>> dv/tps_scanner.sv
`timescale 1ns/1ns
module tps_scanner (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench control
  input  wire logic       go,
  input  wire logic [2:0] sel,
  input  wire logic [3:0] reps,
  input  wire logic [7:0] lag,
  // completion seen from the meter
  input  wire logic       done_n,
  // trigger lines, bit 6 is the jack
  output logic      [6:0] trig_n
);
  logic       done_q;
  logic [3:0] left;
  logic [8:0] wait_c;
  logic [2:0] low_c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b1;
      left   <= 4'h0;
      wait_c <= 9'h000;
      low_c  <= 3'h0;
    end else begin
      done_q <= done_n;
      if (low_c != 3'h0) low_c <= low_c - 3'h1;
      if (go) begin
        left   <= reps;
        wait_c <= {1'b0, lag} + 9'h001;
      end else if (wait_c != 9'h000) begin
        wait_c <= wait_c - 9'h001;
        if (wait_c == 9'h001) begin
          low_c <= 3'h4;
          left  <= left - 4'h1;
        end
      end else if (done_n && !done_q && left != 4'h0) begin
        // answer only once the meter pulse has ended, like a scanner closing a channel
        wait_c <= {1'b0, lag} + 9'h001;
      end
    end
  end

  // lines idle high through their pull-ups; only the selected line is pulled low
  assign trig_n = (low_c != 3'h0) ? ~(7'h01 << sel) : 7'h7F;
endmodule // tps_scanner

// >>> dv/tps_props.sv
`timescale 1ns/1ns
module tps_props import tps_pkg::*; (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // trigger side
  input wire logic        meter_done_n,
  input wire logic [5:0]  bus_out,
  input wire logic [5:0]  bus_oe,
  input wire logic        meas_start,
  input wire logic        armed
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite && paddr == OFS_CTRL;

  property p_rdy; psel && $rose(penable) |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready too long");
  property p_noreq; !(psel && penable) |-> !pready; endproperty
  a_noreq: assert property (p_noreq) else $error("pready without access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_halt; ctl_wr && pwdata[0] |=> !armed; endproperty
  a_halt: assert property (p_halt) else $error("halt did not disarm");
  property p_stay; !armed && !(ctl_wr && pwdata[1]) |=> !armed; endproperty
  a_stay: assert property (p_stay) else $error("armed without key");
  property p_key; ctl_wr && pwdata[1:0] == 2'b10 && !armed |=> armed; endproperty
  a_key: assert property (p_key) else $error("key did not arm");
  property p_ms; meas_start |-> armed ##1 !meas_start; endproperty
  a_ms: assert property (p_ms) else $error("bad measurement start");
  property p_pulse; $fell(meter_done_n) |=> !meter_done_n [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("completion pulse short");
  property p_busl; $rose(|bus_oe) |-> bus_out == ~bus_oe ##1 (|bus_oe) [*8]; endproperty
  a_busl: assert property (p_busl) else $error("bus line not active low");
endmodule // tps_props

bind tps_top tps_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .meter_done_n(meter_done_n), .bus_out(bus_out), .bus_oe(bus_oe), .meas_start(meas_start), .armed(armed));

// >>> dv/tps_top_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tps_top_test import tps_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic        ext_trig_n, meter_done_n, meas_start, armed, go, done_n, md_q, oe_q;
  logic [5:0]  bus_in, bus_out, bus_oe;
  logic [2:0]  sel, inl, outl;
  logic [3:0]  reps;
  logic [7:0]  lag;
  logic [6:0]  trig_n;
  logic [15:0] dly;
  int          n_fail = 0, n_compared = 0, n_ms = 0, n_md = 0, n_bo = 0, cyc = 0, t_ms = 0, gap = 0;
  int          seed, k, b_ms, b_md, b_bo;
  logic [2:0]  srcs [6] = '{SRC_EXT, SRC_BUS, SRC_BUS, SRC_EXT, SRC_HOLD, SRC_EXT};
  int          e_ms [6] = '{3, 3, 0, 0, 0, 0};
  int          e_md [6] = '{3, 0, 0, 0, 0, 0};
  int          e_bo [6] = '{0, 3, 0, 0, 0, 0};

  tps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_n(ext_trig_n), .meter_done_n(meter_done_n), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .meas_start(meas_start), .armed(armed));
  tps_scanner u_scan (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel), .reps(reps), .lag(lag),
    .done_n(done_n), .trig_n(trig_n));
  assign ext_trig_n = trig_n[6];
  assign bus_in = trig_n[5:0];
  assign done_n = (sel == 3'h6) ? meter_done_n : ~bus_oe[outl];

  function automatic logic [31:0] cfg(input logic [2:0] s, input logic m, input logic [2:0] i, input logic [2:0] o);
    return {21'h0, s, 1'b0, m, i, o};
  endfunction
  function automatic logic [2:0] rline();
    return 3'($unsigned($random(seed)) % 6);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i == 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, pulse counters
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    final_report();
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    md_q <= meter_done_n;
    oe_q <= bus_oe[outl];
    if (meas_start === 1'b1) begin
      n_ms <= n_ms + 1;
      t_ms <= cyc;
    end
    if (meter_done_n === 1'b0 && md_q === 1'b1) begin
      n_md <= n_md + 1;
      gap <= cyc - t_ms;
    end
    if (bus_oe[outl] === 1'b1 && oe_q === 1'b0) n_bo <= n_bo + 1;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 69;
    {presetn, psel, penable, pwrite, go, paddr, pwdata, reps, lag, outl} = '0;
    sel = 3'h6;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("armed", 1'b0, armed)
    `CHK("jack idle", 1'b1, meter_done_n)
    `CHK("bus idle", 6'h00, bus_oe)
    apb(1'b0, OFS_COUNT, 32'h0);
    `CHK("count", {2'b00, COUNT_RST}, rd)
    inl = rline();
    do outl = rline(); while (outl == inl);
    w = cfg(3'($unsigned($random(seed)) % 6), MODE_ASYNC, inl, outl);
    apb(1'b1, OFS_MEAS, w);
    apb(1'b0, OFS_MEAS, 32'h0);
    `CHK("cfg", w, rd)
    apb(1'b1, OFS_MEAS, cfg(SRC_BUS, MODE_ASYNC, inl, inl));
    apb(1'b0, OFS_MEAS, 32'h0);
    `CHK("same line", w, rd)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("cfg err", 1'b1, rd[STAT_ERR_BIT])
    apb(1'b1, OFS_STATUS, 32'h1 << STAT_ERR_BIT);
    w = cfg(SRC_BUS, 1'b1, inl, inl);
    apb(1'b1, OFS_MEAS, w);
    apb(1'b0, OFS_MEAS, 32'h0);
    `CHK("shared line", w, rd)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("err clear", 1'b0, rd[STAT_ERR_BIT])
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    dly = 16'($unsigned($random(seed)) % 16);
    apb(1'b1, OFS_DELAY, {16'h0, dly});
    for (int i = 0; i < 6; i++) begin
      inl = rline();
      do outl = rline(); while (outl == inl);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b1, OFS_MEAS, cfg(SRC_HOLD, MODE_ASYNC, inl, outl));
      apb(1'b1, OFS_CTRL, 32'h2);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("state", 3'(ST_MEAS), rd[2:0])
      apb(1'b1, OFS_MEAS, cfg(srcs[i], MODE_ASYNC, inl, outl));
      if (i == 5) begin
        apb(1'b1, OFS_CTRL, 32'h1);
        `CHK("halted", 1'b0, armed)
      end
      // slow and prompt answers both occur through the random lag
      sel <= (i == 1 || i == 3) ? inl : 3'h6;
      reps <= 4'h3;
      lag <= 8'($unsigned($random(seed)) % 24);
      go <= 1'b1;
      b_ms = n_ms;
      b_md = n_md;
      b_bo = n_bo;
      @(posedge pclk);
      go <= 1'b0;
      k = 0;
      while (n_ms - b_ms < e_ms[i] && k < 3000) begin
        @(posedge pclk);
        k++;
      end
      repeat (300) @(posedge pclk);
      `CHK("starts", e_ms[i], n_ms - b_ms)
      `CHK("jack pulses", e_md[i], n_md - b_md)
      `CHK("bus pulses", e_bo[i], n_bo - b_bo)
      if (i == 0) `CHK("settle", 1'b1, gap >= dly + SETTLE_CYC - 1 && gap <= dly + SETTLE_CYC + 2)
    end
    // scan bypass with external source: bypass on the first pass only, return path pulses the jack
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_COUNT, {2'b00, COUNT_RST} | 32'h00000001);
    apb(1'b1, OFS_SCAN, cfg(SRC_EXT, MODE_ASYNC, 3'h0, 3'h1) | 32'h00000080);
    apb(1'b1, OFS_MEAS, cfg(SRC_BUS, MODE_ASYNC, inl, outl));
    b_ms = n_ms;
    b_md = n_md;
    b_bo = n_bo;
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("bypass", 3'(ST_MEAS), rd[2:0])
    // key stands in for a bus trigger; one measurement ends the count and returns to the scan layer
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("scan wait", 3'(ST_SCAN), rd[2:0])
    // the scanner left waiting by the last loop pass answers the jack pulse with one edge
    repeat (300) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("scan ext", 3'(ST_MEAS), rd[2:0])
    `CHK("return starts", 1, n_ms - b_ms)
    `CHK("return jack", 1, n_md - b_md)
    `CHK("return bus", 1, n_bo - b_bo)
    final_report();
  end
endmodule // tps_top_test
